/* File: design/smb_pkg.sv */
// Constants, carriers and state codes of the bus transfer sequencer.
// Assumes a 25 MHz system clock and a 32-bit classic Wishbone master.
package smb_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_OWN  = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0c;
  localparam logic [7:0] ADDR_CFG  = 8'h10;

  // Control register fields
  localparam int CTL_IRQ    = 0;
  localparam int CTL_ACK    = 1;
  localparam int CTL_LOST   = 2;
  localparam int CTL_ACKREQ = 3;
  localparam int CTL_STOP   = 4;
  localparam int CTL_START  = 5;
  localparam int CTL_TX     = 6;
  localparam int CTL_MASTER = 7;

  // Configuration register fields
  localparam int CFG_EN      = 0;
  localparam int CFG_INHIBIT = 1;

  // Reset values
  localparam logic [7:0] OWN_RST  = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hfe;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [1:0] CFG_RST  = 2'h0;

  localparam logic [6:0] GENCALL_ADDR = 7'h00;

  // Bit counter marks
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_ONE  = 4'h1;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT  = 4'h8;

  // Serial clock timing
  localparam int CLK_NS       = 40;
  localparam int SCL_HALF_NS  = 5000;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int TIMER_W      = 8;

  typedef struct packed {
    logic scl;
    logic sda;
  } smb_pins_type;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_START = 5'b00010,
    ST_XFER  = 5'b00100,
    ST_HOLD  = 5'b01000,
    ST_STOP  = 5'b10000
  } smb_state_type;

endpackage

/* File: design/smb_sequencer.sv */
// Transfer mode sequencer of a two-wire bus controller, master and slave.
// Assumes open-drain pins resolved outside and a classic Wishbone master.
// Contract
// - Always exactly one of four modes
// - Master from own START until lost/STOP
// - Interrupt at end of every byte
// - Receive: interrupt before ack unless hw ack
// - Transmit: interrupt always after ack cycle
// - Write: START, address with write bit, data
// - Stop request ends master transfer with STOP
// - No data write after tx irq: receiver
// - Read: address with read bit, clock in data
// - No hw ack: set ack request, interrupt
// - Hw ack: drive preset ack, then interrupt
// - Ack bit one acks, zero nacks
// - Data write as master receiver: transmitter
// - Not inhibited: START plus address enters slave
// - No hw ack: address interrupt, software acks
// - Hw ack: ack matching address, then interrupt
// - Nacked address: no slave events until START
// - Slave receiver ends on STOP, write: transmitter
// - Slave transmitter: STOP ends, no write: receiver
// - Top four control bits form status
// - Shift msb first, data holds last byte
// - Compare only address bits with mask set
// - Hw ack enable selects automatic recognition
// - General call accepted only when enabled
//
// Implementation choices: the placing of the registers and the Wishbone register port.
module smb_sequencer
  import smb_pkg::*;
#(
  parameter logic [TIMER_W-1:0] HALF_CYC = TIMER_W'(SCL_HALF_CYC)
)
(
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  input  wire smb_pins_type  pin_in,
  output smb_pins_type       pin_out,
  output smb_pins_type       pin_oe
);

  smb_state_type       state, next_state;
  logic                master, next_master;
  logic                tx, next_tx;
  logic                start_request_bit, next_start;
  logic                stop_request, next_stop;
  logic                ackb, next_ackb;
  logic                lost, next_lost;
  logic                ack_request_flag, next_ackreq;
  logic [3:0]          bit_cnt, next_bit_cnt;
  logic                scl_low, next_scl_low;
  logic                sda_low, next_sda_low;
  logic                early, next_early;
  logic                addr_phase, next_addr_phase;
  logic                wrote, next_wrote;
  logic                irq_flag, raise_irq, tload;
  logic [7:0]          serial_data_reg, own_address_reg, address_mask_reg;
  logic [1:0]          cfg;
  logic [TIMER_W-1:0]  timer;
  logic                busy, scl_q, sda_q;
  smb_pins_type        lines;

  smb_sync #(.WIDTH(2)) u_sync
  (
    .mclk     (mclk),
    .rst      (rst),
    .async_in (pin_in),
    .sync_out (lines)
  );

  // Bus line decoding
  wire scl_s     = lines.scl;
  wire sda_s     = lines.sda;
  wire scl_rise  = scl_s & ~scl_q;
  wire scl_fall  = ~scl_s & scl_q;
  wire start_det = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_det  = scl_s & scl_q & ~sda_q & sda_s;
  wire tdone     = (timer == '0);

  // Register bus decoding
  wire        wb_hit  = wb_cyc_i & wb_stb_i;
  wire        wr_en   = wb_hit & wb_we_i & wb_ack_o & wb_sel_i[0];
  wire        wr_ctrl = wr_en & (wb_adr_i == ADDR_CTRL);
  wire        wr_data = wr_en & (wb_adr_i == ADDR_DATA);
  wire        wr_own  = wr_en & (wb_adr_i == ADDR_OWN);
  wire        wr_mask = wr_en & (wb_adr_i == ADDR_MASK);
  wire        wr_cfg  = wr_en & (wb_adr_i == ADDR_CFG);
  wire [7:0]  wdat    = wb_dat_i[7:0];

  wire       hw_ack_enable       = address_mask_reg[0];
  wire       general_call_enable = own_address_reg[0];
  wire [6:0] slave_address_bits  = own_address_reg[7:1];
  wire [6:0] address_mask_bits   = address_mask_reg[7:1];
  wire       enable              = cfg[CFG_EN];
  wire       slave_inhibit_bit   = cfg[CFG_INHIBIT];

  // Status vector in the upper four bits
  wire [7:0] ctrl_rd = {master, tx, start_request_bit, stop_request,
                        ack_request_flag, lost, ackb, irq_flag};
  wire [7:0] rd_byte = (wb_adr_i == ADDR_CTRL) ? ctrl_rd :
                       (wb_adr_i == ADDR_DATA) ? serial_data_reg :
                       (wb_adr_i == ADDR_OWN)  ? own_address_reg :
                       (wb_adr_i == ADDR_MASK) ? address_mask_reg :
                       (wb_adr_i == ADDR_CFG)  ? {6'h00, cfg} : 8'h00;

  // Masked own address and general call match
  wire addr_match = (((serial_data_reg[7:1] ^ slave_address_bits) & address_mask_bits) == '0)
                  | (general_call_enable & (serial_data_reg[7:1] == GENCALL_ADDR));
  wire shift_en   = (state == ST_XFER) & scl_rise & (bit_cnt != ACK_BIT);
  wire tx_lose    = master & tx & ~sda_low & ~sda_s & (bit_cnt != ACK_BIT);
  wire ign_addr   = addr_phase & ~master & ~sda_low;

  assign pin_out    = '0;
  assign pin_oe.scl = scl_low;
  assign pin_oe.sda = sda_low;

  always_comb
  begin
    next_state      = state;
    next_master     = master;
    next_tx         = tx;
    next_start      = start_request_bit;
    next_stop       = stop_request;
    next_ackb       = ackb;
    next_lost       = lost;
    next_ackreq     = ack_request_flag;
    next_bit_cnt    = bit_cnt;
    next_scl_low    = scl_low;
    next_sda_low    = sda_low;
    next_early      = early;
    next_addr_phase = addr_phase;
    next_wrote      = wrote;
    tload           = 1'b0;
    raise_irq       = 1'b0;
    if (wr_ctrl)
    begin
      next_start = wdat[CTL_START];
      next_stop  = wdat[CTL_STOP];
      next_ackb  = wdat[CTL_ACK];
      next_lost  = lost & wdat[CTL_LOST];
    end
    if (wr_data & irq_flag)
      next_wrote = 1'b1;
    unique case (state)
      ST_IDLE:
      begin
        tload        = 1'b1;
        next_scl_low = 1'b0;
        next_sda_low = 1'b0;
        if (start_request_bit & enable & ~busy)
          next_state = ST_START;
      end
      ST_START:
      begin
        if (scl_low)
        begin
          if (tdone)
          begin
            next_scl_low = 1'b0;
            tload        = 1'b1;
          end
        end
        else if (~sda_low)
        begin
          if (tdone & scl_s & sda_s)
          begin
            next_sda_low = 1'b1;
            tload        = 1'b1;
          end
        end
        else if (tdone)
        begin
          // Own START makes us master transmitter
          next_scl_low = 1'b1;
          next_master  = 1'b1;
          next_tx      = 1'b1;
          next_lost    = 1'b0;
          next_bit_cnt = BIT_ZERO;
          raise_irq    = 1'b1;
          next_state   = ST_HOLD;
        end
      end
      ST_STOP:
      begin
        if (scl_low)
        begin
          if (tdone)
          begin
            next_scl_low = 1'b0;
            tload        = 1'b1;
          end
        end
        else if (tdone & scl_s)
        begin
          next_sda_low = 1'b0;
          next_master  = 1'b0;
          next_stop    = 1'b0;
          next_state   = ST_IDLE;
        end
      end
      ST_HOLD:
      begin
        tload        = 1'b1;
        next_scl_low = 1'b1;
        if (~irq_flag)
        begin
          next_wrote   = 1'b0;
          next_ackreq  = 1'b0;
          next_tx      = wrote;
          next_scl_low = master;
          if (master & (bit_cnt != ACK_BIT) & stop_request)
          begin
            next_state   = ST_STOP;
            next_sda_low = 1'b1;
          end
          else if (master & (bit_cnt != ACK_BIT) & start_request_bit)
          begin
            next_state   = ST_START;
            next_sda_low = 1'b0;
          end
          else
          begin
            next_state   = ST_XFER;
            // Software ack drives the held ack slot
            next_sda_low = (bit_cnt == ACK_BIT) ? ackb : (wrote & ~serial_data_reg[7]);
          end
        end
      end
      ST_XFER:
      begin
        // Own clock, stretched by a slow slave
        if (master)
        begin
          if (~scl_low & ~scl_s)
            tload = 1'b1;
          else if (tdone)
          begin
            tload        = 1'b1;
            next_scl_low = ~scl_low;
          end
        end
        if (scl_rise)
        begin
          if (tx_lose)
          begin
            next_master  = 1'b0;
            next_tx      = 1'b0;
            next_lost    = 1'b1;
            next_scl_low = 1'b0;
            next_sda_low = 1'b0;
          end
          else if ((bit_cnt == ACK_BIT) & tx)
            next_ackb = ~sda_s;
        end
        if (scl_fall)
        begin
          if (bit_cnt == ACK_BIT)
          begin
            next_bit_cnt    = BIT_ZERO;
            next_addr_phase = 1'b0;
            next_early      = 1'b0;
            next_sda_low    = early & tx & ~serial_data_reg[7];
            if (ign_addr)
              next_state = ST_IDLE;
            else if (~early)
            begin
              raise_irq  = 1'b1;
              next_state = ST_HOLD;
            end
            else if (master & stop_request)
            begin
              next_state   = ST_STOP;
              next_sda_low = 1'b1;
            end
            else if (master & start_request_bit)
            begin
              next_state   = ST_START;
              next_sda_low = 1'b0;
            end
          end
          else
          begin
            next_bit_cnt = bit_cnt + BIT_ONE;
            if (bit_cnt != LAST_BIT)
              next_sda_low = tx & ~serial_data_reg[7];
            else if (tx)
              next_sda_low = 1'b0;
            else if (~hw_ack_enable)
            begin
              raise_irq    = 1'b1;
              next_ackreq  = 1'b1;
              next_early   = 1'b1;
              next_sda_low = 1'b0;
              next_state   = ST_HOLD;
            end
            else
              next_sda_low = (addr_phase & ~master) ? addr_match : ackb;
          end
        end
      end
    endcase
    if (stop_det & (state != ST_START))
    begin
      next_state      = ST_IDLE;
      next_master     = 1'b0;
      next_tx         = 1'b0;
      next_addr_phase = 1'b0;
      next_early      = 1'b0;
      next_scl_low    = 1'b0;
      next_sda_low    = 1'b0;
    end
    if (start_det & ~master & (state != ST_START) & enable & ~slave_inhibit_bit)
    begin
      next_state      = ST_XFER;
      next_tx         = 1'b0;
      next_bit_cnt    = BIT_ZERO;
      next_addr_phase = 1'b1;
      next_early      = 1'b0;
      next_scl_low    = 1'b0;
      next_sda_low    = 1'b0;
    end
    if (~enable)
    begin
      next_state   = ST_IDLE;
      next_master  = 1'b0;
      next_scl_low = 1'b0;
      next_sda_low = 1'b0;
    end
  end

  // Mode is the pair master and tx
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state             <= ST_IDLE;
      master            <= 1'b0;
      tx                <= 1'b0;
      start_request_bit <= 1'b0;
      stop_request      <= 1'b0;
      ackb              <= 1'b0;
      lost              <= 1'b0;
      ack_request_flag  <= 1'b0;
      bit_cnt           <= BIT_ZERO;
      scl_low           <= 1'b0;
      sda_low           <= 1'b0;
      early             <= 1'b0;
      addr_phase        <= 1'b0;
      wrote             <= 1'b0;
    end
    else
    begin
      state             <= next_state;
      master            <= next_master;
      tx                <= next_tx;
      start_request_bit <= next_start;
      stop_request      <= next_stop;
      ackb              <= next_ackb;
      lost              <= next_lost;
      ack_request_flag  <= next_ackreq;
      bit_cnt           <= next_bit_cnt;
      scl_low           <= next_scl_low;
      sda_low           <= next_sda_low;
      early             <= next_early;
      addr_phase        <= next_addr_phase;
      wrote             <= next_wrote;
    end
  end

  // Interrupt flag: hardware set wins over software clear
  always_ff @(posedge mclk)
  begin
    if (rst)
      irq_flag <= 1'b0;
    else
      irq_flag <= raise_irq | (irq_flag & ~(wr_ctrl & ~wdat[CTL_IRQ]));
  end

  // Data shifts msb first and keeps the last byte seen
  always_ff @(posedge mclk)
  begin
    if (rst)
      serial_data_reg <= DATA_RST;
    else if (wr_data)
      serial_data_reg <= wdat;
    else if (shift_en)
      serial_data_reg <= {serial_data_reg[6:0], sda_s};
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      own_address_reg  <= OWN_RST;
      address_mask_reg <= MASK_RST;
      cfg              <= CFG_RST;
    end
    else
    begin
      if (wr_own)
        own_address_reg <= wdat;
      if (wr_mask)
        address_mask_reg <= wdat;
      if (wr_cfg)
        cfg <= wdat[1:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      busy  <= 1'b0;
      timer <= HALF_CYC;
    end
    else
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      busy  <= start_det | (busy & ~stop_det);
      timer <= tload ? HALF_CYC : (tdone ? timer : timer - 1'b1);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= wb_hit & ~wb_ack_o;
      if (wb_hit & ~wb_ack_o)
        wb_dat_o <= {24'h000000, rd_byte};
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  mode_state_a: assert property ($onehot(state))
    else $error("state code not one-hot");

  start_master_a: assert property (
    (state == ST_START) && (next_state == ST_HOLD)
    |=> master && tx && irq_flag && (bit_cnt == BIT_ZERO))
    else $error("own START did not enter master transmitter");

  rx_irq_before_a: assert property (
    (state == ST_XFER) && scl_fall && (bit_cnt == LAST_BIT) && !tx && !hw_ack_enable
    && enable && !start_det && !stop_det
    |=> irq_flag && ack_request_flag && (bit_cnt == ACK_BIT) && !pin_oe.sda)
    else $error("receive interrupt not before ack");

  hw_ack_after_a: assert property (
    (state == ST_XFER) && scl_fall && (bit_cnt == LAST_BIT) && !tx && hw_ack_enable
    && enable && !start_det && !stop_det
    |=> !irq_flag && (bit_cnt == ACK_BIT)
    && (pin_oe.sda == $past((addr_phase && !master) ? addr_match : ackb)))
    else $error("hardware ack slot wrong");

  tx_irq_after_a: assert property ($rose(irq_flag) && !ack_request_flag |-> bit_cnt == BIT_ZERO)
    else $error("transmit interrupt not after ack");

  hold_scl_a: assert property ((state == ST_HOLD) [*2] |-> pin_oe.scl)
    else $error("clock not held during interrupt");

  stop_end_a: assert property (
    (state == ST_STOP) ##1 (state == ST_IDLE) |-> !master && !stop_request && !pin_oe.sda)
    else $error("STOP did not leave master");

  mode_switch_a: assert property (
    (state == ST_HOLD) && !irq_flag && enable && !stop_det && !start_det |=> tx == $past(wrote))
    else $error("mode switch on release wrong");

  addr_ignore_a: assert property (
    (state == ST_XFER) && scl_fall && (bit_cnt == ACK_BIT) && ign_addr && enable
    && !start_det && !stop_det |=> (state == ST_IDLE) ##1 !irq_flag)
    else $error("ignored address raised slave events");

  msb_first_a: assert property (shift_en && !wr_data |=> serial_data_reg[0] == $past(sda_s))
    else $error("data not shifted msb first");

endmodule

/* File: design/smb_sync.sv */
// Two-flop synchroniser for the bus pin levels.
// Assumes inputs asynchronous to mclk; rst synchronous, active high.
module smb_sync
#(
  parameter int WIDTH = 2
)
(
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    always_ff @(posedge mclk)
    begin
      if (rst)
      begin
        meta[i]     <= 1'b1;
        sync_out[i] <= 1'b1;
      end
      else
      begin
        meta[i]     <= async_in[i];
        sync_out[i] <= meta[i];
      end
    end
  end

endmodule

/* File: tb/smb_slave_model.sv */
// Behavioural bus slave that answers the sequencer while it acts as master.
// Assumes resolved wired-AND line levels with pull-ups; drives only its own pull-down.
module smb_slave_model
#(
  parameter logic [6:0] OWN_ADDR = 7'h50,
  parameter logic [7:0] TX_BYTE  = 8'h96
)
(
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_oe,
  output logic [7:0]      last_byte,
  output logic            last_ack
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] bit_cnt    = 4'h0;
  logic [7:0] shift      = 8'h00;
  logic       active     = 1'b0;
  logic       reading    = 1'b0;
  logic       addr_phase = 1'b0;

  initial
  begin
    sda_oe    = 1'b0;
    last_byte = 8'h00;
    last_ack  = 1'b1;
  end

  // Start condition opens a frame
  always @(negedge sda)
    if (scl)
    begin
      active     = 1'b1;
      addr_phase = 1'b1;
      reading    = 1'b0;
      bit_cnt    = 4'h0;
    end

  // Stop condition closes it
  always @(posedge sda)
    if (scl)
      active = 1'b0;

  always @(posedge scl)
    if (active && bit_cnt < 4'h8)
    begin
      shift   = {shift[6:0], sda};
      bit_cnt = bit_cnt + 4'h1;
    end
    else if (active)
    begin
      last_ack = sda;
      if (addr_phase)
      begin
        reading    = shift[0];
        addr_phase = 1'b0;
        active     = (shift[7:1] == OWN_ADDR);
      end
      else if (reading)
        active = !sda;
      else
        last_byte = shift;
      bit_cnt = 4'h0;
    end

  // Own line changes only while the clock is low
  always @(negedge scl)
    if (!active)
      sda_oe = 1'b0;
    else if (bit_cnt == 4'h8)
      sda_oe = addr_phase ? (shift[7:1] == OWN_ADDR) : !reading;
    else
      sda_oe = reading && !TX_BYTE[3'h7 - bit_cnt[2:0]];
endmodule

/* File: tb/smbus_transfer_mode_sequencer_bench.sv */
// Self-checking bench of the sequencer acting as bus master.
// Assumes one slave model on a wired-AND bus with pull-ups.
module smbus_transfer_mode_sequencer_bench
  import smb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [6:0] SLV   = 7'h50;
  localparam logic [7:0] RBYTE = 8'h96;

  logic         mclk       = 1'b0;
  logic         rst        = 1'b1;
  logic         cyc        = 1'b0;
  logic         stb        = 1'b0;
  logic         we         = 1'b0;
  logic [7:0]   adr        = 8'h00;
  logic [3:0]   sel        = 4'h1;
  logic [31:0]  wdat       = 32'h00000000;
  logic [31:0]  rdat;
  logic         ack;
  smb_pins_type pin_in;
  smb_pins_type pin_oe;
  logic         slave_oe;
  logic [7:0]   slave_byte;
  logic         slave_ack;
  int           err_total  = 0;
  int           n_compared = 0;

  always #20 mclk = ~mclk;

  // Wired-AND of all pull-downs
  assign pin_in = {~pin_oe.scl, ~(pin_oe.sda | slave_oe)};

  smb_sequencer #(.HALF_CYC(8'h08)) u_smb_sequencer
  (
    .mclk     (mclk),
    .rst      (rst),
    .wb_cyc_i (cyc),
    .wb_stb_i (stb),
    .wb_we_i  (we),
    .wb_adr_i (adr),
    .wb_sel_i (sel),
    .wb_dat_i (wdat),
    .wb_dat_o (rdat),
    .wb_ack_o (ack),
    .pin_in   (pin_in),
    .pin_out  (),
    .pin_oe   (pin_oe)
  );

  smb_slave_model #(.OWN_ADDR(SLV), .TX_BYTE(RBYTE)) u_smb_slave_model
  (
    .scl       (pin_in.scl),
    .sda       (pin_in.sda),
    .sda_oe    (slave_oe),
    .last_byte (slave_byte),
    .last_ack  (slave_ack)
  );

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic fail(input string msg);
    err_total++;
    $display("Error at %0t ns: %s", $time, msg);
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
      fail($sformatf("saw %h, expected %h", seen, exp));
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h000000, d};
    @(posedge mclk);
    while (ack !== 1'b1 && n < 16)
    begin
      @(posedge mclk);
      n++;
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 16)
    begin
      fail("bus ack timeout");
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    wb(1'b0, a, 8'h00, q);
  endtask

  task automatic ctrl_bit(input int b, input logic v);
    logic [7:0] q;
    rd(ADDR_CTRL, q);
    check({7'h00, q[b]}, {7'h00, v});
  endtask

  task automatic wait_ctrl(input int b, input logic v);
    logic [7:0] q;
    int n;
    n = 0;
    rd(ADDR_CTRL, q);
    while (q[b] !== v && n < 400)
    begin
      rd(ADDR_CTRL, q);
      n++;
    end
    if (n == 400)
    begin
      fail("control flag timeout");
      end_of_test();
    end
  endtask

  // Byte event: clock held low, status vector as given
  task automatic irq_status(input logic [3:0] st);
    logic [7:0] q;
    wait_ctrl(CTL_IRQ, 1'b1);
    check({7'h00, pin_oe.scl}, 8'h01);
    rd(ADDR_CTRL, q);
    check({4'h0, q[7:4]}, {4'h0, st});
  endtask

  task automatic stop_xfer(input logic [7:0] c);
    logic [7:0] q;
    wr(ADDR_CTRL, c);
    wait_ctrl(CTL_STOP, 1'b0);
    rd(ADDR_CTRL, q);
    check({4'h0, q[7:4]}, 8'h00);
  endtask

  task automatic start_addr(input logic dir);
    wr(ADDR_CTRL, 8'h20);
    irq_status(4'he);
    wr(ADDR_DATA, {SLV, dir});
    wr(ADDR_CTRL, 8'h00);
    irq_status(4'hc);
    ctrl_bit(CTL_ACK, 1'b1);
  endtask

  initial
  begin
    logic [7:0] q;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rd(ADDR_DATA, q);
    check(q, DATA_RST);
    rd(ADDR_OWN, q);
    check(q, OWN_RST);
    rd(ADDR_MASK, q);
    check(q, MASK_RST);
    wr(8'h14, 8'hff);
    rd(8'h14, q);
    check(q, 8'h00);
    rd(ADDR_CTRL, q);
    check({4'h0, q[7:4]}, 8'h00);
    $display("Test reset values done");

    // Master write of one data byte
    wr(ADDR_CFG, 8'h01);
    start_addr(1'b0);
    wr(ADDR_DATA, 8'h5a);
    wr(ADDR_CTRL, 8'h00);
    irq_status(4'hc);
    check(slave_byte, 8'h5a);
    rd(ADDR_DATA, q);
    check(q, 8'h5a);
    stop_xfer(8'h10);
    $display("Test master write done");

    // Master read, software acknowledge
    start_addr(1'b1);
    wr(ADDR_CTRL, 8'h00);
    irq_status(4'h8);
    ctrl_bit(CTL_ACKREQ, 1'b1);
    rd(ADDR_DATA, q);
    check(q, RBYTE);
    wr(ADDR_CTRL, 8'h02);
    irq_status(4'h8);
    check({7'h00, slave_ack}, 8'h00);
    stop_xfer(8'h10);
    check({7'h00, slave_ack}, 8'h01);
    $display("Test master read soft ack done");

    // Master read, hardware acknowledge preset to NACK, then turn to transmitter
    wr(ADDR_MASK, 8'hff);
    start_addr(1'b1);
    wr(ADDR_CTRL, 8'h00);
    irq_status(4'h8);
    ctrl_bit(CTL_ACKREQ, 1'b0);
    check({7'h00, slave_ack}, 8'h01);
    wr(ADDR_DATA, 8'hc3);
    wr(ADDR_CTRL, 8'h00);
    irq_status(4'hc);
    ctrl_bit(CTL_ACK, 1'b0);
    // No data write after the received nack, only the stop request
    stop_xfer(8'h10);
    $display("Test master read hw ack done");
    end_of_test();
  end
endmodule
